// >>> design/spm_regs.sv
// Operation
// R1 - Receive data register is read-only to all
// R2 - Buffer and shifters have no bus address
// R3 - Transmit word moves whole into transmit shifter
// R4 - Receive data reads return full 32 bits
// R5 - Any DMA window read hits receive data
// R6 - Transmit data writable from both buses
// R7 - Software halts port before changing control
// R8 - Software leaves unmapped offsets untouched
// R9 - FIFO registers decoded on their own bus
// R10 - One aligned word per register, decoded by offset
`timescale 1ns/1ps
module spm_regs
  import spm_pkg::*;
#(
  parameter logic [31:0] FIFO_REV = spm_pkg::FIFO_REV_DEF
)(
  input  wire logic                       sys_clk_i,
  input  wire logic                       nrst_i,
  input  wire logic                       cfg_sel_i,
  input  wire logic                       cfg_wr_i,
  input  wire logic [spm_pkg::ADDR_W-1:0] cfg_addr_i,
  input  wire logic [spm_pkg::DATA_W-1:0] cfg_wdata_i,
  output logic      [spm_pkg::DATA_W-1:0] cfg_rdata_o,
  output logic                            cfg_ack_o,
  input  wire logic                       dma_sel_i,
  input  wire logic                       dma_wr_i,
  input  wire logic [spm_pkg::DATA_W-1:0] dma_wdata_i,
  output logic      [spm_pkg::DATA_W-1:0] dma_rdata_o,
  output logic                            dma_ack_o,
  input  wire logic                       fifo_sel_i,
  input  wire logic                       fifo_wr_i,
  input  wire logic [spm_pkg::ADDR_W-1:0] fifo_addr_i,
  input  wire logic [spm_pkg::DATA_W-1:0] fifo_wdata_i,
  output logic      [spm_pkg::DATA_W-1:0] fifo_rdata_o,
  output logic                            fifo_ack_o,
  input  wire logic [spm_pkg::DATA_W-1:0] rx_word_i,
  input  wire logic                       rx_valid_i,
  input  wire logic                       tx_taken_i,
  output logic      [spm_pkg::DATA_W-1:0] tx_word_o,
  output logic                            tx_full_o,
  output logic      [31:0]                port_ctl_o,
  output logic      [31:0]                rx_ctl_o,
  output logic      [31:0]                tx_ctl_o,
  output logic      [31:0]                rate_cfg_o,
  output logic      [31:0]                mc_ctl_o,
  output logic      [31:0]                pin_ctl_o,
  output logic      [127:0]               rx_chan_en_o,
  output logic      [127:0]               tx_chan_en_o,
  output logic      [31:0]                wfifo_ctl_o,
  output logic      [31:0]                rfifo_ctl_o
);
  import spm_pkg::*;

  logic [31:0] rx_data_r, rx_buf_r, tx_data_r, tx_shift_r, port_ctl_r;
  logic [31:0] rx_ctl_r, tx_ctl_r, rate_cfg_r, mc_ctl_r, pin_ctl_r;
  logic [31:0] wfifo_ctl_r, rfifo_ctl_r, cfg_rdata_nxt, fifo_rdata_nxt, tx_wdata;
  logic [31:0] rx_en_r [4];
  logic [31:0] tx_en_r [4];
  logic        rx_buf_full_r, tx_shift_full_r, rx_rdy_r, rx_over_r, tx_rdy_r, tx_rst_d_r;
  logic        cfg_wr, cfg_rd_rx, dma_rd, dma_wr, rx_read, tx_write;
  logic        tx_copy, rx_copy, tx_rst, rx_rst;

  assign cfg_wr    = cfg_sel_i & cfg_wr_i;
  assign cfg_rd_rx = cfg_sel_i & ~cfg_wr_i & (cfg_addr_i == OFF_RX_DATA);
  assign dma_rd    = dma_sel_i & ~dma_wr_i;
  assign dma_wr    = dma_sel_i & dma_wr_i;
  assign rx_read   = cfg_rd_rx | dma_rd;                           // [R5]
  assign tx_write  = (cfg_wr & (cfg_addr_i == OFF_TX_DATA)) | dma_wr; // [R6]
  assign tx_wdata  = (cfg_wr & (cfg_addr_i == OFF_TX_DATA)) ? cfg_wdata_i : dma_wdata_i;
  assign tx_rst    = port_ctl_r[POS_TX_RST];
  assign rx_rst    = port_ctl_r[POS_RX_RST];
  assign tx_copy   = tx_rst & tx_rst_d_r & ~tx_rdy_r & ~tx_shift_full_r & ~tx_write;
  assign rx_copy   = rx_rst & rx_buf_full_r & (~rx_rdy_r | rx_read);

  // Transmit data word and its ready flag
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tx_data_r  <= RST_WORD;
      tx_rdy_r   <= 1'b0;
      tx_rst_d_r <= 1'b0;
    end
    else
    begin
      tx_rst_d_r <= tx_rst;
      if (tx_write)
        tx_data_r <= tx_wdata;                                      // [R6]
      if (!tx_rst)
        tx_rdy_r <= 1'b0;
      else if (tx_copy || !tx_rst_d_r)
        tx_rdy_r <= 1'b1;
      else if (tx_write)
        tx_rdy_r <= 1'b0;
    end
  end

  // Transmit shifter, internal only
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tx_shift_r      <= RST_WORD;
      tx_shift_full_r <= 1'b0;
    end
    else if (!tx_rst)
      tx_shift_full_r <= 1'b0;
    else if (tx_copy)
    begin
      tx_shift_r      <= tx_data_r;                                 // [R3] [R2]
      tx_shift_full_r <= 1'b1;
    end
    else if (tx_taken_i)
      tx_shift_full_r <= 1'b0;
  end

  // Receive buffer, internal only
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_buf_r      <= RST_WORD;
      rx_buf_full_r <= 1'b0;
      rx_over_r     <= 1'b0;
    end
    else if (!rx_rst)
    begin
      rx_buf_full_r <= 1'b0;
      rx_over_r     <= 1'b0;
    end
    else
    begin
      if (rx_valid_i)
        rx_buf_r <= rx_word_i;                                      // [R2]
      if (rx_valid_i || rx_copy)
        rx_buf_full_r <= rx_valid_i;
      if (rx_copy || (rx_valid_i && rx_buf_full_r))
        rx_over_r <= !rx_copy;
    end
  end

  // Receive data register, loaded only from the buffer
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_data_r <= RST_WORD;
      rx_rdy_r  <= 1'b0;
    end
    else
    begin
      if (rx_copy)
        rx_data_r <= rx_buf_r;                                      // [R1] [R4]
      if (!rx_rst)
        rx_rdy_r <= 1'b0;
      else if (rx_copy)
        rx_rdy_r <= 1'b1;
      else if (rx_read)
        rx_rdy_r <= 1'b0;
    end
  end

  // Port control writable fields
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      port_ctl_r <= RST_WORD;
    else if (cfg_wr && cfg_addr_i == OFF_PORT_CTL)
    begin
      port_ctl_r              <= cfg_wdata_i & PORT_CTL_WMASK;
      port_ctl_r[POS_TX_SERR] <= cfg_wdata_i[POS_TX_SERR] & cfg_wdata_i[POS_TX_RST] & tx_rst;
    end
  end

  // Plain control registers of the main map
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_ctl_r   <= RST_WORD;
      tx_ctl_r   <= RST_WORD;
      rate_cfg_r <= RST_WORD;
      mc_ctl_r   <= RST_WORD;
      pin_ctl_r  <= RST_WORD;
      for (int i = 0; i < 4; i++)
      begin
        rx_en_r[i] <= RST_WORD;
        tx_en_r[i] <= RST_WORD;
      end
    end
    else if (cfg_wr)
    begin
      case (cfg_addr_i)                                             // [R10]
        OFF_RX_CTL:   rx_ctl_r   <= cfg_wdata_i;
        OFF_TX_CTL:   tx_ctl_r   <= cfg_wdata_i;
        OFF_RATE_CFG: rate_cfg_r <= cfg_wdata_i;
        OFF_MC_CTL:   mc_ctl_r   <= cfg_wdata_i;
        OFF_PIN_CTL:  pin_ctl_r  <= cfg_wdata_i;
        OFF_RX_EN_AB: rx_en_r[0] <= cfg_wdata_i;
        OFF_TX_EN_AB: tx_en_r[0] <= cfg_wdata_i;
        OFF_RX_EN_CD: rx_en_r[1] <= cfg_wdata_i;
        OFF_TX_EN_CD: tx_en_r[1] <= cfg_wdata_i;
        OFF_RX_EN_EF: rx_en_r[2] <= cfg_wdata_i;
        OFF_TX_EN_EF: tx_en_r[2] <= cfg_wdata_i;
        OFF_RX_EN_GH: rx_en_r[3] <= cfg_wdata_i;
        OFF_TX_EN_GH: tx_en_r[3] <= cfg_wdata_i;
        default: ;
      endcase
    end
  end

  // Main map read decode
  always_comb
  begin
    case (cfg_addr_i)                                               // [R10] [R2]
      OFF_RX_DATA:  cfg_rdata_nxt = rx_data_r;                      // [R4]
      OFF_TX_DATA:  cfg_rdata_nxt = tx_data_r;
      OFF_PORT_CTL:
      begin
        cfg_rdata_nxt               = port_ctl_r;
        cfg_rdata_nxt[POS_RX_RDY]   = rx_rdy_r;
        cfg_rdata_nxt[POS_RX_FULL]  = rx_over_r;
        cfg_rdata_nxt[POS_TX_RDY]   = tx_rdy_r;
        cfg_rdata_nxt[POS_TX_EMPTY] = tx_shift_full_r;
      end
      OFF_RX_CTL:   cfg_rdata_nxt = rx_ctl_r;
      OFF_TX_CTL:   cfg_rdata_nxt = tx_ctl_r;
      OFF_RATE_CFG: cfg_rdata_nxt = rate_cfg_r;
      OFF_MC_CTL:   cfg_rdata_nxt = mc_ctl_r;
      OFF_PIN_CTL:  cfg_rdata_nxt = pin_ctl_r;
      OFF_RX_EN_AB: cfg_rdata_nxt = rx_en_r[0];
      OFF_TX_EN_AB: cfg_rdata_nxt = tx_en_r[0];
      OFF_RX_EN_CD: cfg_rdata_nxt = rx_en_r[1];
      OFF_TX_EN_CD: cfg_rdata_nxt = tx_en_r[1];
      OFF_RX_EN_EF: cfg_rdata_nxt = rx_en_r[2];
      OFF_TX_EN_EF: cfg_rdata_nxt = tx_en_r[2];
      OFF_RX_EN_GH: cfg_rdata_nxt = rx_en_r[3];
      OFF_TX_EN_GH: cfg_rdata_nxt = tx_en_r[3];
      default:      cfg_rdata_nxt = RST_WORD;
    endcase
  end

  // Buffer FIFO control registers on their own bus
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wfifo_ctl_r <= RST_WORD;
      rfifo_ctl_r <= RST_WORD;
    end
    else if (fifo_sel_i && fifo_wr_i)
    begin
      if (fifo_addr_i == OFF_WFIFO_CTL)
        wfifo_ctl_r <= fifo_wdata_i;                                // [R9]
      if (fifo_addr_i == OFF_RFIFO_CTL)
        rfifo_ctl_r <= fifo_wdata_i;                                // [R9]
    end
  end

  always_comb
  begin
    case (fifo_addr_i)                                              // [R9] [R10]
      OFF_FIFO_REV:  fifo_rdata_nxt = FIFO_REV;
      OFF_WFIFO_CTL: fifo_rdata_nxt = wfifo_ctl_r;
      OFF_WFIFO_STS: fifo_rdata_nxt = {30'h0, tx_shift_full_r, ~tx_rdy_r & tx_rst};
      OFF_RFIFO_CTL: fifo_rdata_nxt = rfifo_ctl_r;
      OFF_RFIFO_STS: fifo_rdata_nxt = {30'h0, rx_buf_full_r, rx_rdy_r};
      default:       fifo_rdata_nxt = RST_WORD;
    endcase
  end

  // Registered read answers, one cycle after the request
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg_rdata_o  <= RST_WORD;
      cfg_ack_o    <= 1'b0;
      dma_rdata_o  <= RST_WORD;
      dma_ack_o    <= 1'b0;
      fifo_rdata_o <= RST_WORD;
      fifo_ack_o   <= 1'b0;
    end
    else
    begin
      cfg_ack_o  <= cfg_sel_i;
      dma_ack_o  <= dma_sel_i;
      fifo_ack_o <= fifo_sel_i;
      if (cfg_sel_i && !cfg_wr_i)
        cfg_rdata_o <= cfg_rdata_nxt;
      if (dma_rd)
        dma_rdata_o <= rx_data_r;                                   // [R5]
      if (fifo_sel_i && !fifo_wr_i)
        fifo_rdata_o <= fifo_rdata_nxt;
    end
  end

  assign tx_word_o    = tx_shift_r;
  assign tx_full_o    = tx_shift_full_r;
  assign port_ctl_o   = port_ctl_r;
  assign rx_ctl_o     = rx_ctl_r;
  assign tx_ctl_o     = tx_ctl_r;
  assign rate_cfg_o   = rate_cfg_r;
  assign mc_ctl_o     = mc_ctl_r;
  assign pin_ctl_o    = pin_ctl_r;
  assign rx_chan_en_o = {rx_en_r[3], rx_en_r[2], rx_en_r[1], rx_en_r[0]};
  assign tx_chan_en_o = {tx_en_r[3], tx_en_r[2], tx_en_r[1], tx_en_r[0]};
  assign wfifo_ctl_o  = wfifo_ctl_r;
  assign rfifo_ctl_o  = rfifo_ctl_r;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  rx_data_ro_a: assert property (!rx_copy |=> $stable(rx_data_r))   // [R1]
    else $error("receive data changed without a buffer copy");
  rx_full_word_a: assert property (rx_copy |=> rx_data_r == $past(rx_buf_r)) // [R4]
    else $error("receive data not equal to buffer word");
  dma_rx_alias_a: assert property (dma_rd |=> dma_ack_o && dma_rdata_o == $past(rx_data_r)) // [R5]
    else $error("dma read did not return receive data");
  dma_tx_write_a: assert property (dma_wr && !cfg_wr |=> tx_data_r == $past(dma_wdata_i)) // [R6]
    else $error("dma write not stored in transmit data");
  cfg_tx_write_a: assert property (cfg_wr && cfg_addr_i == OFF_TX_DATA |=> tx_data_r == $past(cfg_wdata_i)) // [R6]
    else $error("config write not stored in transmit data");
  tx_shift_load_a: assert property (tx_copy |=> tx_shift_full_r && tx_rdy_r && tx_shift_r == $past(tx_data_r)) // [R3]
    else $error("transmit shifter load wrong");
  tx_ready_drop_a: assert property (tx_write && tx_rst && tx_rst_d_r |=> !tx_rdy_r) // [R3]
    else $error("transmit ready not cleared by write");
  cfg_decode_a: assert property (cfg_sel_i && !cfg_wr_i && cfg_addr_i == OFF_MC_CTL |=> cfg_rdata_o == $past(mc_ctl_r)) // [R10]
    else $error("offset decode read wrong register");
  fifo_rev_a: assert property (fifo_sel_i && !fifo_wr_i && fifo_addr_i == OFF_FIFO_REV |=> fifo_rdata_o == FIFO_REV) // [R9]
    else $error("fifo revision read wrong");
  fifo_sep_a: assert property (cfg_wr && !(fifo_sel_i && fifo_wr_i) |=> $stable(wfifo_ctl_r) && $stable(rfifo_ctl_r)) // [R9]
    else $error("main bus write reached fifo registers");
  rx_path_c: cover property (rx_valid_i ##[1:4] rx_rdy_r ##[1:4] rx_read);
  tx_path_c: cover property (tx_write ##[1:4] tx_copy ##[1:8] tx_taken_i);
  dma_both_c: cover property (dma_wr ##1 dma_rd);
  fifo_acc_c: cover property (fifo_sel_i && fifo_wr_i && fifo_addr_i == OFF_WFIFO_CTL);
endmodule : spm_regs

// >>> design/spm_pkg.sv
package spm_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // Main port map
  localparam logic [7:0] OFF_RX_DATA   = 8'h00;
  localparam logic [7:0] OFF_TX_DATA   = 8'h04;
  localparam logic [7:0] OFF_PORT_CTL  = 8'h08;
  localparam logic [7:0] OFF_RX_CTL    = 8'h0c;
  localparam logic [7:0] OFF_TX_CTL    = 8'h10;
  localparam logic [7:0] OFF_RATE_CFG  = 8'h14;
  localparam logic [7:0] OFF_MC_CTL    = 8'h18;
  localparam logic [7:0] OFF_RX_EN_AB  = 8'h1c;
  localparam logic [7:0] OFF_TX_EN_AB  = 8'h20;
  localparam logic [7:0] OFF_PIN_CTL   = 8'h24;
  localparam logic [7:0] OFF_RX_EN_CD  = 8'h28;
  localparam logic [7:0] OFF_TX_EN_CD  = 8'h2c;
  localparam logic [7:0] OFF_RX_EN_EF  = 8'h30;
  localparam logic [7:0] OFF_TX_EN_EF  = 8'h34;
  localparam logic [7:0] OFF_RX_EN_GH  = 8'h38;
  localparam logic [7:0] OFF_TX_EN_GH  = 8'h3c;
  // Buffer FIFO map
  localparam logic [7:0] OFF_FIFO_REV  = 8'h00;
  localparam logic [7:0] OFF_WFIFO_CTL = 8'h10;
  localparam logic [7:0] OFF_WFIFO_STS = 8'h14;
  localparam logic [7:0] OFF_RFIFO_CTL = 8'h18;
  localparam logic [7:0] OFF_RFIFO_STS = 8'h1c;
  // Port control field positions
  localparam int unsigned POS_RX_RST   = 0;
  localparam int unsigned POS_RX_RDY   = 1;
  localparam int unsigned POS_RX_FULL  = 2;
  localparam int unsigned POS_TX_RST   = 16;
  localparam int unsigned POS_TX_RDY   = 17;
  localparam int unsigned POS_TX_EMPTY = 18;
  localparam int unsigned POS_TX_SERR  = 19;
  // Bits software may write in port control (status and reserved excluded)
  localparam logic [31:0] PORT_CTL_WMASK = 32'h03f9_f8f9;
  // Reset values
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  // Revision code, value arbitrary
  localparam logic [31:0] FIFO_REV_DEF = 32'h0001_0000;
endpackage : spm_pkg

// >>> dv/spm_host_model.sv
`timescale 1ns/1ps
module spm_host_model
  import spm_pkg::*;
(
  input  wire logic                 sys_clk_i,
  output logic      [2:0]           sel_o,
  output logic                      wr_o,
  output logic      [7:0]           addr_o,
  output logic      [31:0]          wdata_o,
  input  wire logic [2:0][31:0]     rdata_i,
  input  wire logic [2:0]           ack_i
);
  initial
  begin
    sel_o   = 3'h0;
    wr_o    = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 32'h0000_0000;
  end
  // Bus k: 0 main, 1 DMA, 2 FIFO; one whole word per access
  // Control writes are issued only while the port is halted, except the second port control write, issued once enabled
  // Unmapped offsets are only ever read, never written
  task automatic acc(input int k, input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd, output logic ak);
    @(negedge sys_clk_i);
    sel_o    = 3'h0;
    sel_o[k] = 1'b1;
    wr_o     = w;
    addr_o   = a;
    wdata_o  = d;
    @(negedge sys_clk_i);
    sel_o    = 3'h0;
    wr_o     = ~w;
    addr_o   = ~a;
    wdata_o  = ~d;
    ak       = ack_i[k];
    rd       = rdata_i[k];
  endtask : acc
endmodule : spm_host_model

// >>> dv/serial_port_register_map_bench.sv
`timescale 1ns/1ps
module serial_port_register_map_bench;
  import spm_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic [2:0]  sel;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wd, cfg_rd, dma_rd, fifo_rd, rx_word, tx_word;
  logic        cfg_ak, dma_ak, fifo_ak, rx_valid, tx_taken, tx_full;
  logic [31:0] port_ctl, rx_ctl, tx_ctl, rate_cfg, mc_ctl, pin_ctl, wfifo_ctl, rfifo_ctl;
  logic [127:0] rx_en, tx_en;
  int          ri [4] = '{7, 10, 12, 14};
  logic [31:0] seed = 32'd2629;
  logic [31:0] m [16];
  logic [31:0] d, d2;
  int          error_cnt  = 0;
  int          n_compared = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  spm_host_model u_host (.sys_clk_i(sys_clk_i), .sel_o(sel), .wr_o(wr), .addr_o(addr),
    .wdata_o(wd), .rdata_i({fifo_rd, dma_rd, cfg_rd}), .ack_i({fifo_ak, dma_ak, cfg_ak}));

  spm_regs dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .cfg_sel_i(sel[0]), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_wdata_i(wd),
    .cfg_rdata_o(cfg_rd), .cfg_ack_o(cfg_ak),
    .dma_sel_i(sel[1]), .dma_wr_i(wr), .dma_wdata_i(wd), .dma_rdata_o(dma_rd), .dma_ack_o(dma_ak),
    .fifo_sel_i(sel[2]), .fifo_wr_i(wr), .fifo_addr_i(addr), .fifo_wdata_i(wd),
    .fifo_rdata_o(fifo_rd), .fifo_ack_o(fifo_ak),
    .rx_word_i(rx_word), .rx_valid_i(rx_valid), .tx_taken_i(tx_taken),
    .tx_word_o(tx_word), .tx_full_o(tx_full), .port_ctl_o(port_ctl), .rx_ctl_o(rx_ctl), .tx_ctl_o(tx_ctl),
    .rate_cfg_o(rate_cfg), .mc_ctl_o(mc_ctl), .pin_ctl_o(pin_ctl), .rx_chan_en_o(rx_en), .tx_chan_en_o(tx_en),
    .wfifo_ctl_o(wfifo_ctl), .rfifo_ctl_o(rfifo_ctl));

  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nxt

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic rd(input int k, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        ak;
    u_host.acc(k, 1'b0, a, nxt(), r, ak);
    check("ack", {31'h0, ak}, 32'h0000_0001);
    check($sformatf("read %0d/%h", k, a), r, exp);
  endtask : rd

  task automatic wt(input int k, input logic [7:0] a, input logic [31:0] v);
    logic [31:0] r;
    logic        ak;
    u_host.acc(k, 1'b1, a, v, r, ak);
    check("ack", {31'h0, ak}, 32'h0000_0001);
  endtask : wt

  task automatic rx_push(input logic [31:0] w);
    @(negedge sys_clk_i);
    rx_word  = w;
    rx_valid = 1'b1;
    @(negedge sys_clk_i);
    rx_valid = 1'b0;
    rx_word  = ~w;
  endtask : rx_push

  task automatic close_out();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    #50000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    rx_word  = 32'h0000_0000;
    rx_valid = 1'b0;
    tx_taken = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    // Reset values and the two maps
    for (int i = 0; i < 16; i++) rd(0, 8'(i * 4), RST_WORD);
    rd(2, OFF_FIFO_REV, FIFO_REV_DEF);
    rd(2, 8'h04, 32'h0000_0000);
    // No address reaches buffer or shifters
    for (int i = 16; i < 64; i++) rd(0, 8'(i * 4), 32'h0000_0000);
    // Random read back of plain control words
    for (int i = 3; i < 16; i++)
    begin
      m[i] = nxt();
      wt(0, 8'(i * 4), m[i]);
      rd(0, 8'(i * 4), m[i]);
    end
    check("rx ctl", rx_ctl, m[3]);
    check("tx ctl", tx_ctl, m[4]);
    check("rate cfg", rate_cfg, m[5]);
    check("mc ctl", mc_ctl, m[6]);
    check("pin ctl", pin_ctl, m[9]);
    check("port ctl", port_ctl, RST_WORD);
    for (int i = 0; i < 4; i++)
    begin
      check("rx chan en", rx_en[i*32 +: 32], m[ri[i]]);
      check("tx chan en", tx_en[i*32 +: 32], m[ri[i] + 1]);
    end
    d = nxt();
    wt(2, OFF_WFIFO_CTL, d);
    rd(2, OFF_WFIFO_CTL, d);
    wt(2, OFF_RFIFO_CTL, ~d);
    rd(2, OFF_RFIFO_CTL, ~d);
    check("wfifo ctl", wfifo_ctl, d);
    check("rfifo ctl", rfifo_ctl, ~d);
    rd(0, OFF_TX_CTL, m[4]);
    rd(0, OFF_MC_CTL, m[6]);
    // Receive data refuses writes
    wt(0, OFF_RX_DATA, nxt());
    rd(0, OFF_RX_DATA, 32'h0000_0000);
    // Enable both halves; sync error only settable once enabled
    wt(0, OFF_PORT_CTL, 32'hffff_ffff);
    rd(0, OFF_PORT_CTL, 32'h03f3_f8f9);
    wt(0, OFF_PORT_CTL, 32'hffff_ffff);
    rd(0, OFF_PORT_CTL, 32'h03fb_f8f9);
    check("port ctl", port_ctl, 32'h03f9_f8f9);
    // Transmit word moves whole into the shifter
    d = nxt();
    wt(0, OFF_TX_DATA, d);
    @(negedge sys_clk_i);
    check("tx word", tx_word, d);
    check("tx full", {31'h0, tx_full}, 32'h0000_0001);
    d2 = nxt();
    wt(1, 8'h00, d2);
    rd(0, OFF_TX_DATA, d2);
    rd(2, OFF_WFIFO_STS, 32'h0000_0003);
    check("tx hold", tx_word, d);
    rd(0, OFF_RX_DATA, 32'h0000_0000);
    tx_taken = 1'b1;
    @(negedge sys_clk_i);
    tx_taken = 1'b0;
    @(negedge sys_clk_i);
    check("tx next", tx_word, d2);
    rd(2, OFF_WFIFO_STS, 32'h0000_0002);
    // Receive: all ones, then a random word
    for (int k = 0; k < 2; k++)
    begin
      d = (k == 0) ? 32'hffff_ffff : nxt();
      rx_push(d);
      repeat (2) @(negedge sys_clk_i);
      rd(2, OFF_RFIFO_STS, 32'h0000_0001);
      rd(1, 8'h00, d);
      rd(0, OFF_RX_DATA, d);
    end
    // Three words into an unread receiver: the middle one is overrun
    for (int k = 0; k < 3; k++)
    begin
      m[k] = nxt();
      rx_push(m[k]);
    end
    rd(0, OFF_PORT_CTL, 32'h03ff_f8ff);
    rd(0, OFF_RX_DATA, m[0]);
    rd(1, 8'h00, m[2]);
    close_out();
  end
endmodule : serial_port_register_map_bench
